// File: ssm_pkg.sv
// Package of constants shared by the supply supervisor mode control block.
package ssm_pkg;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int SETTLE_FULL_PS   = 2000000;
   localparam int SETTLE_NORMAL_PS = 150000000;
   localparam int WAKE_FAST_PS     = 2000000;
   localparam int WAKE_SLOW_PS     = 150000000;
   localparam int SETTLE_FULL_CYC  =
      (SETTLE_FULL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETTLE_NORMAL_CYC =
      (SETTLE_NORMAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_FAST_CYC    =
      (WAKE_FAST_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAKE_SLOW_CYC    =
      (WAKE_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIMER_W          = 16;

   // ********************************************************************
   // Register map
   // ********************************************************************
   localparam logic [7:0] LOW_CTL_OFS  = 8'h00;
   localparam logic [7:0] HIGH_CTL_OFS = 8'h04;
   localparam logic [7:0] FLAG_OFS     = 8'h08;
   localparam logic [7:0] MASK_OFS     = 8'h0C;
   localparam logic [7:0] STATE_OFS    = 8'h10;

   // Control register fields, same layout for both sides.
   localparam int CTL_SUP_EN   = 0;
   localparam int CTL_SUP_KEEP = 1;
   localparam int CTL_SUP_FP   = 2;
   localparam int CTL_MON_EN   = 3;
   localparam int CTL_MON_FP   = 4;
   localparam int CTL_AUTO     = 5;
   localparam int CTL_RST_EN   = 6;
   localparam int CTL_W        = 7;
   localparam logic [6:0] CTL_RESET = 7'h49;

   // Flag register: event bits 0..3, delay flags 4 and 5.
   localparam int EV_SUP_LOW  = 0;
   localparam int EV_SUP_HIGH = 1;
   localparam int EV_MON_LOW  = 2;
   localparam int EV_MON_HIGH = 3;
   localparam int EV_N        = 4;
   localparam int FLG_DLY_LOW  = 4;
   localparam int FLG_DLY_HIGH = 5;
   localparam logic [3:0] MASK_RESET = 4'h0;

   // ********************************************************************
   // Power modes and unit states
   // ********************************************************************
   localparam logic [2:0] PM_ACTIVE = 3'h0;
   localparam logic [2:0] PM_LPM2   = 3'h3;

   typedef enum logic [2:0] {
      SSM_OFF    = 3'b001,
      SSM_NORMAL = 3'b010,
      SSM_FULL   = 3'b100
   } ssm_state_e;

endpackage

// File: ssm_settle_timer.sv
// Down-counting delay timer used for settling masks and wake hold-off.
module ssm_settle_timer #(
   parameter int W = 16
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         start,
   input  wire logic [W-1:0] load_cycles,
   output logic              busy
);
   logic [W-1:0] count_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count_ff <= '0;
      end else if (ce) begin
         if (start) begin
            count_ff <= load_cycles;
         end else if (count_ff != '0) begin
            count_ff <= count_ff - W'(1);
         end
      end
   end

   assign busy = (count_ff != '0);
endmodule // ssm_settle_timer

// File: ssm_mode_control.sv
// Supply supervisor and monitor mode control with settling and wake delays.
//
// Decided for this implementation: the strobed register port and the address map.

module ssm_mode_control #(
   parameter int SETTLE_NORMAL_CYC = ssm_pkg::SETTLE_NORMAL_CYC,
   parameter int WAKE_SLOW_CYC     = ssm_pkg::WAKE_SLOW_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic        power_up_clear,
   input  wire logic [2:0]  power_mode,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [3:0]  comparator_event,
   output logic [2:0]       low_supervisor_state,
   output logic [2:0]       low_monitor_state,
   output logic [2:0]       high_supervisor_state,
   output logic [2:0]       high_monitor_state,
   output logic             por_request,
   output logic             gpio_float,
   output logic             cpu_hold,
   output logic             periph_clk_enable,
   output logic             irq
);
   localparam logic [ssm_pkg::TIMER_W-1:0] FULL_CYC =
      ssm_pkg::TIMER_W'(ssm_pkg::SETTLE_FULL_CYC);
   localparam logic [ssm_pkg::TIMER_W-1:0] NORM_CYC =
      ssm_pkg::TIMER_W'(SETTLE_NORMAL_CYC);
   localparam logic [ssm_pkg::TIMER_W-1:0] WFAST_CYC =
      ssm_pkg::TIMER_W'(ssm_pkg::WAKE_FAST_CYC);
   localparam logic [ssm_pkg::TIMER_W-1:0] WSLOW_CYC =
      ssm_pkg::TIMER_W'(WAKE_SLOW_CYC);

   logic [ssm_pkg::CTL_W-1:0] low_side_control_reg_ff;
   logic [ssm_pkg::CTL_W-1:0] high_side_control_reg_ff;
   logic [ssm_pkg::EV_N-1:0]  power_flag_reg_ff;
   logic [ssm_pkg::EV_N-1:0]  irq_mask_ff;
   logic [ssm_pkg::EV_N-1:0]  ev_meta_ff;
   logic [ssm_pkg::EV_N-1:0]  ev_sync_ff;
   logic [ssm_pkg::EV_N-1:0]  ev_valid;
   logic [31:0]               reg_rdata_ff;
   logic [2:0]                power_mode_prev_ff;
   logic                      por_request_ff;
   logic                      gpio_float_ff;
   logic                      init_ff;
   logic                      deep;
   logic                      wake;
   logic                      slow_wake;
   logic                      low_busy;
   logic                      high_busy;
   logic                      wake_busy;
   logic                      low_start;
   logic                      high_start;
   logic                      flag_clear;
   logic [2:0]                low_sup_prev_ff;
   logic [2:0]                high_sup_prev_ff;

   // ********************************************************************
   // Unit state mapping
   // ********************************************************************
   function automatic ssm_pkg::ssm_state_e sup_state(
      input logic en, input logic keep, input logic fp,
      input logic auto_ctl, input logic lpm_deep);
      ssm_pkg::ssm_state_e s;
      s = ssm_pkg::SSM_OFF;
      if (en && !lpm_deep) begin
         s = fp ? ssm_pkg::SSM_FULL : ssm_pkg::SSM_NORMAL;
      end else if (en && !auto_ctl && keep) begin
         s = fp ? ssm_pkg::SSM_FULL : ssm_pkg::SSM_NORMAL;
      end else if (en && auto_ctl && keep && fp) begin
         s = ssm_pkg::SSM_NORMAL;
      end
      return s;
   endfunction

   function automatic ssm_pkg::ssm_state_e mon_state(
      input logic en, input logic fp, input logic auto_ctl,
      input logic lpm_deep);
      ssm_pkg::ssm_state_e s;
      s = ssm_pkg::SSM_OFF;
      if (en && (!lpm_deep || !auto_ctl)) begin
         s = fp ? ssm_pkg::SSM_FULL : ssm_pkg::SSM_NORMAL;
      end else if (en && fp) begin
         s = ssm_pkg::SSM_NORMAL;
      end
      return s;
   endfunction

   assign deep = (power_mode >= ssm_pkg::PM_LPM2);
   assign wake = (power_mode_prev_ff >= ssm_pkg::PM_LPM2) && !deep;

   always_comb begin
      low_supervisor_state = sup_state(
         low_side_control_reg_ff[ssm_pkg::CTL_SUP_EN],
         low_side_control_reg_ff[ssm_pkg::CTL_SUP_KEEP],
         low_side_control_reg_ff[ssm_pkg::CTL_SUP_FP],
         low_side_control_reg_ff[ssm_pkg::CTL_AUTO], deep);
      high_supervisor_state = sup_state(
         high_side_control_reg_ff[ssm_pkg::CTL_SUP_EN],
         high_side_control_reg_ff[ssm_pkg::CTL_SUP_KEEP],
         high_side_control_reg_ff[ssm_pkg::CTL_SUP_FP],
         high_side_control_reg_ff[ssm_pkg::CTL_AUTO], deep);
      low_monitor_state = mon_state(
         low_side_control_reg_ff[ssm_pkg::CTL_MON_EN],
         low_side_control_reg_ff[ssm_pkg::CTL_MON_FP],
         low_side_control_reg_ff[ssm_pkg::CTL_AUTO], deep);
      high_monitor_state = mon_state(
         high_side_control_reg_ff[ssm_pkg::CTL_MON_EN],
         high_side_control_reg_ff[ssm_pkg::CTL_MON_FP],
         high_side_control_reg_ff[ssm_pkg::CTL_AUTO], deep);
   end

   // ********************************************************************
   // Register port
   // ********************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         low_side_control_reg_ff  <= ssm_pkg::CTL_RESET;
         high_side_control_reg_ff <= ssm_pkg::CTL_RESET;
         irq_mask_ff              <= ssm_pkg::MASK_RESET;
      end else if (ce) begin
         if (reg_wr && reg_addr == ssm_pkg::LOW_CTL_OFS) begin
            low_side_control_reg_ff <= reg_wdata[ssm_pkg::CTL_W-1:0];
         end
         if (reg_wr && reg_addr == ssm_pkg::HIGH_CTL_OFS) begin
            high_side_control_reg_ff <= reg_wdata[ssm_pkg::CTL_W-1:0];
         end
         if (reg_wr && reg_addr == ssm_pkg::MASK_OFS) begin
            irq_mask_ff <= reg_wdata[ssm_pkg::EV_N-1:0];
         end
         if (power_up_clear) begin
            low_side_control_reg_ff[ssm_pkg::CTL_SUP_EN]  <= 1'b1;
            high_side_control_reg_ff[ssm_pkg::CTL_SUP_EN] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reg_rdata_ff <= 32'h0000_0000;
      end else if (ce) begin
         reg_rdata_ff <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               ssm_pkg::LOW_CTL_OFS:
                  reg_rdata_ff <= {25'h0, low_side_control_reg_ff};
               ssm_pkg::HIGH_CTL_OFS:
                  reg_rdata_ff <= {25'h0, high_side_control_reg_ff};
               ssm_pkg::FLAG_OFS:
                  reg_rdata_ff <= {26'h0, high_busy, low_busy,
                                   power_flag_reg_ff};
               ssm_pkg::MASK_OFS:
                  reg_rdata_ff <= {28'h0, irq_mask_ff};
               ssm_pkg::STATE_OFS:
                  reg_rdata_ff <= {20'h0, high_monitor_state,
                                   high_supervisor_state,
                                   low_monitor_state,
                                   low_supervisor_state};
               default:
                  reg_rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end
   assign reg_rdata = reg_rdata_ff;

   // ********************************************************************
   // Settling delays
   // ********************************************************************
   // Settling restarts on a control write, on a supervisor changing its
   // state, on the release of reset and on a supervisor event.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         init_ff            <= 1'b1;
         low_sup_prev_ff    <= ssm_pkg::SSM_OFF;
         high_sup_prev_ff   <= ssm_pkg::SSM_OFF;
         power_mode_prev_ff <= ssm_pkg::PM_ACTIVE;
      end else if (ce) begin
         init_ff            <= power_up_clear;
         low_sup_prev_ff    <= low_supervisor_state;
         high_sup_prev_ff   <= high_supervisor_state;
         power_mode_prev_ff <= power_mode;
      end
   end

   assign low_start  = init_ff
      || (reg_wr && reg_addr == ssm_pkg::LOW_CTL_OFS)
      || (low_supervisor_state != low_sup_prev_ff)
      || ev_valid[ssm_pkg::EV_SUP_LOW];
   assign high_start = init_ff
      || (reg_wr && reg_addr == ssm_pkg::HIGH_CTL_OFS)
      || (high_supervisor_state != high_sup_prev_ff)
      || ev_valid[ssm_pkg::EV_SUP_HIGH];

   ssm_settle_timer #(.W(ssm_pkg::TIMER_W)) u_low_settle (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .ce          (ce),
      .start       (low_start),
      .load_cycles ((low_supervisor_state == ssm_pkg::SSM_NORMAL) ?
                    NORM_CYC : FULL_CYC),
      .busy        (low_busy)
   );

   ssm_settle_timer #(.W(ssm_pkg::TIMER_W)) u_high_settle (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .ce          (ce),
      .start       (high_start),
      .load_cycles ((high_supervisor_state == ssm_pkg::SSM_NORMAL) ?
                    NORM_CYC : FULL_CYC),
      .busy        (high_busy)
   );

   // ********************************************************************
   // Wake hold-off
   // ********************************************************************
   assign slow_wake =
      (low_side_control_reg_ff[ssm_pkg::CTL_SUP_EN]
         && !low_side_control_reg_ff[ssm_pkg::CTL_SUP_FP])
      || (low_side_control_reg_ff[ssm_pkg::CTL_MON_EN]
         && !low_side_control_reg_ff[ssm_pkg::CTL_MON_FP]);

   ssm_settle_timer #(.W(ssm_pkg::TIMER_W)) u_wake_hold (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .ce          (ce),
      .start       (wake),
      .load_cycles (slow_wake ? WSLOW_CYC : WFAST_CYC),
      .busy        (wake_busy)
   );

   // Only execution waits; the peripheral clock runs through the wake.
   assign cpu_hold          = wake_busy;
   assign periph_clk_enable = rst_n;

   // ********************************************************************
   // Events, flags and interrupt
   // ********************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ev_meta_ff <= 4'h0;
         ev_sync_ff <= 4'h0;
      end else if (ce) begin
         ev_meta_ff <= comparator_event;
         ev_sync_ff <= ev_meta_ff;
      end
   end

   assign ev_valid[ssm_pkg::EV_SUP_LOW] = ev_sync_ff[ssm_pkg::EV_SUP_LOW]
      && low_supervisor_state != ssm_pkg::SSM_OFF && !low_busy;
   assign ev_valid[ssm_pkg::EV_SUP_HIGH] = ev_sync_ff[ssm_pkg::EV_SUP_HIGH]
      && high_supervisor_state != ssm_pkg::SSM_OFF && !high_busy;
   assign ev_valid[ssm_pkg::EV_MON_LOW] = ev_sync_ff[ssm_pkg::EV_MON_LOW]
      && low_monitor_state != ssm_pkg::SSM_OFF && !low_busy;
   assign ev_valid[ssm_pkg::EV_MON_HIGH] = ev_sync_ff[ssm_pkg::EV_MON_HIGH]
      && high_monitor_state != ssm_pkg::SSM_OFF && !high_busy;

   assign flag_clear = reg_rd && reg_addr == ssm_pkg::FLAG_OFS;

   // A new event in the clearing cycle keeps its flag set.
   genvar gi;
   generate
      for (gi = 0; gi < ssm_pkg::EV_N; gi++) begin : g_flag
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               power_flag_reg_ff[gi] <= 1'b0;
            end else if (ce) begin
               if (ev_valid[gi]) begin
                  power_flag_reg_ff[gi] <= 1'b1;
               end else if (flag_clear) begin
                  power_flag_reg_ff[gi] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         por_request_ff <= 1'b0;
         gpio_float_ff  <= 1'b0;
      end else if (ce) begin
         por_request_ff <= (ev_valid[ssm_pkg::EV_SUP_LOW]
            && low_side_control_reg_ff[ssm_pkg::CTL_RST_EN])
            || (ev_valid[ssm_pkg::EV_SUP_HIGH]
            && high_side_control_reg_ff[ssm_pkg::CTL_RST_EN]);
         if (ev_valid[ssm_pkg::EV_SUP_LOW]
               || ev_valid[ssm_pkg::EV_SUP_HIGH]) begin
            gpio_float_ff <= 1'b1;
         end else if (!low_busy && !high_busy) begin
            gpio_float_ff <= 1'b0;
         end
      end
   end

   assign por_request = por_request_ff;
   assign gpio_float  = gpio_float_ff;
   assign irq         = |(power_flag_reg_ff & irq_mask_ff);

   // ********************************************************************
   // Checks
   // ********************************************************************
   property p_mask_full;
      @(posedge ref_clk) disable iff (!rst_n)
      low_busy && ce |=> !$rose(power_flag_reg_ff[ssm_pkg::EV_SUP_LOW]);
   endproperty
   a_mask_full: assert property (p_mask_full)
      else $error("low supervisor flag rose during settling mask");

   property p_event_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      ce && ev_valid[ssm_pkg::EV_SUP_HIGH]
         |=> power_flag_reg_ff[ssm_pkg::EV_SUP_HIGH];
   endproperty
   a_event_flag: assert property (p_event_flag)
      else $error("supervisor event did not set its flag");

   property p_por_req;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(por_request) |-> $past(ev_valid[ssm_pkg::EV_SUP_LOW]
         || ev_valid[ssm_pkg::EV_SUP_HIGH]);
   endproperty
   a_por_req: assert property (p_por_req)
      else $error("reset request without supervisor event");

   property p_float;
      @(posedge ref_clk) disable iff (!rst_n)
      ce && ev_valid[ssm_pkg::EV_SUP_LOW] |=> gpio_float ##1 gpio_float;
   endproperty
   a_float: assert property (p_float)
      else $error("pins not floated after supervisor event");

   property p_lpm_off;
      @(posedge ref_clk) disable iff (!rst_n)
      deep && !low_side_control_reg_ff[ssm_pkg::CTL_SUP_KEEP]
         |-> low_supervisor_state == ssm_pkg::SSM_OFF;
   endproperty
   a_lpm_off: assert property (p_lpm_off)
      else $error("low supervisor on in deep mode without keep");

   property p_puc_enable;
      @(posedge ref_clk) disable iff (!rst_n)
      ce && power_up_clear |=> low_side_control_reg_ff[ssm_pkg::CTL_SUP_EN]
         && high_side_control_reg_ff[ssm_pkg::CTL_SUP_EN];
   endproperty
   a_puc_enable: assert property (p_puc_enable)
      else $error("supervisors not enabled after power-up clear");

   property p_wake_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      ce && wake |=> cpu_hold [*2];
   endproperty
   a_wake_hold: assert property (p_wake_hold)
      else $error("processor not held after wake");

   property p_delay_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      ce && reg_wr && reg_addr == ssm_pkg::LOW_CTL_OFS |=> low_busy;
   endproperty
   a_delay_flag: assert property (p_delay_flag)
      else $error("low delay flag not set by control write");

   property p_auto_normal;
      @(posedge ref_clk) disable iff (!rst_n)
      deep && (&high_side_control_reg_ff[2:0])
         && high_side_control_reg_ff[ssm_pkg::CTL_AUTO]
         |-> high_supervisor_state == ssm_pkg::SSM_NORMAL;
   endproperty
   a_auto_normal: assert property (p_auto_normal)
      else $error("high supervisor auto mapping wrong");

endmodule // ssm_mode_control

// File: ssm_mode_control_tb.sv
// Self-checking testbench for the supply supervisor mode control block.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ********************************************************************
   // Signals and design instance
   // ********************************************************************
   logic        ref_clk;
   logic        rst_n;
   logic        power_up_clear;
   logic [2:0]  power_mode;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [3:0]  comparator_event;
   logic [2:0]  lss, lms, hss, hms;
   logic        por_request, gpio_float, cpu_hold, periph_clk_enable, irq;
   logic [31:0] v;
   logic [6:0]  lc, hc;
   logic        dp;
   logic        ce;
   int          err_total, checks_done, por_cnt, seed;

   ssm_mode_control #(.SETTLE_NORMAL_CYC(40), .WAKE_SLOW_CYC(40)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
      .power_up_clear(power_up_clear), .power_mode(power_mode),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .comparator_event(comparator_event),
      .low_supervisor_state(lss), .low_monitor_state(lms),
      .high_supervisor_state(hss), .high_monitor_state(hms),
      .por_request(por_request), .gpio_float(gpio_float),
      .cpu_hold(cpu_hold), .periph_clk_enable(periph_clk_enable),
      .irq(irq));

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (por_request === 1'b1) begin
         por_cnt <= por_cnt + 1;
      end
   end
   // ********************************************************************
   // Expectations and bus tasks
   // ********************************************************************
   function automatic logic [2:0] sup_exp(logic en, kp, fp, au, dp);
      if (!en || (dp && !kp) || (dp && au && !fp)) return ssm_pkg::SSM_OFF;
      if (dp && au) return ssm_pkg::SSM_NORMAL;
      return fp ? ssm_pkg::SSM_FULL : ssm_pkg::SSM_NORMAL;
   endfunction

   function automatic logic [2:0] mon_exp(logic en, fp, au, dp);
      if (!en || (dp && au && !fp)) return ssm_pkg::SSM_OFF;
      return (fp && !(dp && au)) ? ssm_pkg::SSM_FULL : ssm_pkg::SSM_NORMAL;
   endfunction

   task automatic chk(input logic [31:0] got, exp, input string msg);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got,
                  exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Polls the flag register until both delay flags have dropped.
   task automatic settle();
      int n;
      n = 0;
      do begin
         rd(ssm_pkg::FLAG_OFS, v);
         n++;
      end while (v[5:4] !== 2'b00 && n < 400);
      chk(32'(v[5:4]), 32'h0, "delay flags stuck");
   endtask

   task automatic ev(input int b);
      @(posedge ref_clk);
      comparator_event <= 4'(1 << b);
      repeat (3) @(posedge ref_clk);
      comparator_event <= 4'h0;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask

   // Sleeps in a deep mode, wakes, and counts processor hold cycles.
   task automatic wake(input int exp);
      int n;
      n = 0;
      settle();
      power_mode <= 3'h4;
      repeat (4) @(posedge ref_clk);
      power_mode <= ssm_pkg::PM_ACTIVE;
      repeat (700) begin
         @(negedge ref_clk);
         if (cpu_hold === 1'b1) n++;
         if (periph_clk_enable !== 1'b1) n += 1000;
      end
      chk(32'(n), 32'(exp), "hold cycles");
   endtask

   task automatic end_sim();
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial begin
      seed = 32'hae6a;
      err_total = 0;
      checks_done = 0;
      por_cnt = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      power_up_clear = 1'b0;
      power_mode = ssm_pkg::PM_ACTIVE;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      comparator_event = 4'h0;
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(ssm_pkg::LOW_CTL_OFS, v);
      chk(v, 32'h49, "low ctl reset");
      rd(ssm_pkg::HIGH_CTL_OFS, v);
      chk(v, 32'h49, "high ctl reset");
      rd(ssm_pkg::FLAG_OFS, v);
      chk(v, 32'h30, "flags after reset");
      rd(ssm_pkg::MASK_OFS, v);
      chk(v, 32'h0, "mask reset");
      rd(8'hFC, v);
      chk(v, 32'h0, "unmapped read");
      for (int i = 0; i < 24; i++) begin
         lc = 7'($random(seed));
         hc = 7'($random(seed));
         wr(ssm_pkg::LOW_CTL_OFS, {25'h0, lc & 7'h6b});
         wr(ssm_pkg::HIGH_CTL_OFS, {25'h0, hc & 7'h6b});
         settle();
         wr(ssm_pkg::LOW_CTL_OFS, {25'h0, lc});
         wr(ssm_pkg::HIGH_CTL_OFS, {25'h0, hc});
         settle();
         power_mode <= 3'({$random(seed)} % 6);
         @(posedge ref_clk);
         #1 dp = power_mode >= ssm_pkg::PM_LPM2;
         chk(32'(lss), 32'(sup_exp(lc[0], lc[1], lc[2], lc[5], dp)), "lss");
         chk(32'(lms), 32'(mon_exp(lc[3], lc[4], lc[5], dp)), "lms");
         chk(32'(hss), 32'(sup_exp(hc[0], hc[1], hc[2], hc[5], dp)), "hss");
         chk(32'(hms), 32'(mon_exp(hc[3], hc[4], hc[5], dp)), "hms");
         rd(ssm_pkg::STATE_OFS, v);
         chk(v, 32'({mon_exp(hc[3], hc[4], hc[5], dp),
                     sup_exp(hc[0], hc[1], hc[2], hc[5], dp),
                     mon_exp(lc[3], lc[4], lc[5], dp),
                     sup_exp(lc[0], lc[1], lc[2], lc[5], dp)}), "state reg");
      end
      power_mode <= ssm_pkg::PM_ACTIVE;
      wr(ssm_pkg::MASK_OFS, 32'hf);
      wr(ssm_pkg::LOW_CTL_OFS, 32'h49);
      wr(ssm_pkg::HIGH_CTL_OFS, 32'h09);
      settle();
      ev(0);
      chk(32'(por_cnt), 32'h1, "reset request");
      chk(32'({gpio_float, irq}), 32'h3, "float and irq");
      rd(ssm_pkg::FLAG_OFS, v);
      chk(v, 32'h11, "low event flag");
      @(posedge ref_clk);
      #1 chk(32'(irq), 32'h0, "irq after read");
      settle();
      repeat (2) @(posedge ref_clk);
      #1 chk(32'(gpio_float), 32'h0, "float after settle");
      ev(1);
      ev(2);
      chk(32'(por_cnt), 32'h1, "no reset request");
      rd(ssm_pkg::FLAG_OFS, v);
      chk(32'(v[3:0]), 32'h6, "high and monitor flags");
      wr(ssm_pkg::LOW_CTL_OFS, 32'h5d);
      repeat (4) @(posedge ref_clk);
      ev(0);
      rd(ssm_pkg::FLAG_OFS, v);
      chk(32'(v[3:0]), 32'h0, "event not masked");
      wake(500);
      wr(ssm_pkg::LOW_CTL_OFS, 32'h49);
      wake(40);
      ce <= 1'b0;
      wr(ssm_pkg::MASK_OFS, 32'h0);
      ce <= 1'b1;
      rd(ssm_pkg::MASK_OFS, v);
      chk(v, 32'hf, "write while frozen");
      wr(ssm_pkg::LOW_CTL_OFS, 32'h0);
      wr(ssm_pkg::HIGH_CTL_OFS, 32'h0);
      @(posedge ref_clk);
      power_up_clear <= 1'b1;
      @(posedge ref_clk);
      power_up_clear <= 1'b0;
      rd(ssm_pkg::LOW_CTL_OFS, v);
      chk(32'(v[0]), 32'h1, "low enable after clear");
      rd(ssm_pkg::HIGH_CTL_OFS, v);
      chk(32'(v[0]), 32'h1, "high enable after clear");
      end_sim();
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      err_total++;
      end_sim();
   end
endmodule // testbench
